// [logic/bscu_pkg.sv]
// shared constants and types of the byte stream checksum unit
package bscu_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h91;
  localparam logic [7:0] IDX_CTRL = 8'h92;
  localparam logic [7:0] IDX_IN = 8'h93;
  localparam logic [7:0] IDX_AUTO = 8'h96;
  localparam logic [7:0] IDX_CNT = 8'h97;

  // control register field positions
  localparam int CTRL_SEL_BIT = 4;
  localparam int CTRL_INIT_BIT = 3;
  localparam int CTRL_VAL_BIT = 2;
  localparam int CTRL_PTR_LSB = 0;

  // auto flash control field positions
  localparam int AUTO_EN_BIT = 7;
  localparam int AUTO_DONE_BIT = 6;
  localparam int AUTO_START_LSB = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IN_RST = 8'h00;
  localparam logic [7:0] AUTO_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;

  // polynomials and seed values
  localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
  localparam logic [31:0] POLY32_REFL = 32'hEDB8_8320;
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [31:0] SEED_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] SEED_ZEROS = 32'h0000_0000;

  // one byte folds in eight bit steps
  localparam int BIT_STEPS = 8;

  // flash geometry: 1024-byte sectors, 64 of them
  localparam int SECTOR_BYTES = 1024;
  localparam int SECTOR_SHIFT = 10;
  localparam int FLASH_AW = 16;

  // automatic run sequencer
  typedef enum logic [2:0] {
    BSCU_IDLE = 3'b001,
    BSCU_READ = 3'b010,
    BSCU_FOLD = 3'b100
  } bscu_auto_st_t;

endpackage : bscu_pkg

// [logic/bscu_crc_engine.sv]
// one-byte update of the checksum accumulator, both polynomials
`timescale 1ns/1ps
module bscu_crc_engine (
  input wire logic [31:0] acc_i,
  input wire logic [7:0] byte_i,
  input wire logic sel16_i,
  output logic [31:0] acc_o
);

  // whole byte in one cycle; a deep xor tree, fine at 20 MHz
  always_comb
  begin
    logic [31:0] a32;
    logic [15:0] a16;
    a32 = acc_i ^ {24'h00_0000, byte_i};
    a16 = acc_i[15:0] ^ {byte_i, 8'h00};
    for (int i = 0; i < bscu_pkg::BIT_STEPS; i++)
    begin
      // reflected form: test lsb, shift right, xor reversed poly
      if (a32[0])
        a32 = (a32 >> 1) ^ bscu_pkg::POLY32_REFL;
      else
        a32 = a32 >> 1;
      // msb-first form for the short polynomial
      if (a16[15])
        a16 = (a16 << 1) ^ bscu_pkg::POLY16;
      else
        a16 = a16 << 1;
    end
    // short mode leaves the upper half untouched
    acc_o = sel16_i ? {acc_i[31:16], a16} : a32;
  end

endmodule : bscu_crc_engine

// [logic/bscu_flash_mem.sv]
// byte-wide flash image with registered read data
`timescale 1ns/1ps
module bscu_flash_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_q [2**AW];

  // storage has no reset; contents come from the load port
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
      mem_q[wr_addr_i] <= wr_data_i;
  end

  // one cycle read latency
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rd_data_o <= '0;
    else if (rd_en_i)
      rd_data_o <= mem_q[rd_addr_i];
  end

endmodule : bscu_flash_mem

// [logic/bscu_top.sv]
// byte stream checksum unit with ahb-lite registers and flash auto mode
`timescale 1ns/1ps
module bscu_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic flash_wr_en_i,
  input wire logic [15:0] flash_wr_addr_i,
  input wire logic [7:0] flash_wr_data_i,
  output logic cpu_hold_o
);

  // every assertion below runs on the one system clock, off in reset
  default clocking main_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // register contents
  logic [31:0] acc_q;
  logic sel16_q;
  logic seed_ones_q;
  logic [1:0] ptr_q;
  logic [7:0] in_q;
  logic auto_en_q;
  logic [5:0] start_q;
  logic [5:0] cnt_q;

  // bus data phase tracking
  logic dp_valid_q;
  logic dp_write_q;
  logic [7:0] dp_idx_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;

  // automatic run state
  bscu_pkg::bscu_auto_st_t st_q;
  logic [15:0] faddr_q;
  logic [15:0] left_q;

  logic busy;
  logic addr_take;
  logic wr_fire;
  logic rd_fire;
  logic ctrl_wr;
  logic in_wr;
  logic data_wr;
  logic data_rd;
  logic auto_wr;
  logic cnt_wr;
  logic auto_go;
  logic [7:0] eng_byte;
  logic [31:0] eng_acc;
  logic [7:0] mem_rdata;

  // map a byte address to a register index, zero when unmapped
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[31:10] != 22'h00_0000 || a[1:0] != 2'b00)
      return 8'h00;
    else if (idx == bscu_pkg::IDX_DATA)
      return idx;
    else if (idx == bscu_pkg::IDX_CTRL)
      return idx;
    else if (idx == bscu_pkg::IDX_IN)
      return idx;
    else if (idx == bscu_pkg::IDX_AUTO)
      return idx;
    else if (idx == bscu_pkg::IDX_CNT)
      return idx;
    else
      return 8'h00;
  endfunction : reg_index

  // result byte seen through the pointer
  function automatic logic [7:0] get_byte(input logic [31:0] acc,
                                          input logic [1:0] ptr,
                                          input logic sel16);
    if (sel16)
      return ptr[0] ? acc[15:8] : acc[7:0];
    else
      return acc[8*ptr +: 8];
  endfunction : get_byte

  // overwrite one result byte through the pointer
  function automatic logic [31:0] put_byte(input logic [31:0] acc,
                                           input logic [1:0] ptr,
                                           input logic sel16,
                                           input logic [7:0] b);
    logic [31:0] r;
    logic [1:0] p;
    r = acc;
    p = sel16 ? {1'b0, ptr[0]} : ptr;
    r[8*p +: 8] = b;
    return r;
  endfunction : put_byte

  assign busy = (st_q != bscu_pkg::BSCU_IDLE);
  assign cpu_hold_o = busy;
  assign addr_take = hsel_i && htrans_i[1] && hready_i;

  // a pending phase waits out an automatic run; reads add one wait
  // state so they always see the effect of the write before them
  assign wr_fire = dp_valid_q && dp_write_q && !busy;
  assign rd_fire = dp_valid_q && !dp_write_q && !busy && !rd_wait_q;
  assign hreadyout_o = !(dp_valid_q && (busy || (!dp_write_q && !rd_wait_q)));
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  // decoded register events
  assign ctrl_wr = wr_fire && (dp_idx_q == bscu_pkg::IDX_CTRL);
  assign in_wr = wr_fire && (dp_idx_q == bscu_pkg::IDX_IN);
  assign data_wr = wr_fire && (dp_idx_q == bscu_pkg::IDX_DATA);
  assign data_rd = rd_fire && (dp_idx_q == bscu_pkg::IDX_DATA);
  assign auto_wr = wr_fire && (dp_idx_q == bscu_pkg::IDX_AUTO);
  assign cnt_wr = wr_fire && (dp_idx_q == bscu_pkg::IDX_CNT);
  assign auto_go = ctrl_wr && auto_en_q && (cnt_q != 6'h00);

  // address phase capture; hsize is ignored, word access only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_idx_q <= 8'h00;
    end
    else if (hready_i)
    begin
      dp_valid_q <= addr_take;
      dp_write_q <= hwrite_i;
      dp_idx_q <= reg_index(haddr_i);
    end
  end

  // read wait state and registered read data
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_wait_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      rd_wait_q <= rd_fire;
      if (rd_fire)
      begin
        hrdata_q <= 32'h0000_0000;
        if (dp_idx_q == bscu_pkg::IDX_CTRL)
          // bits 7:5 and the init strobe read back as zero
          hrdata_q[7:0] <= {3'b000, sel16_q, 1'b0, seed_ones_q,
                            ptr_q};
        else if (dp_idx_q == bscu_pkg::IDX_IN)
          hrdata_q[7:0] <= in_q;
        else if (dp_idx_q == bscu_pkg::IDX_DATA)
          hrdata_q[7:0] <= get_byte(acc_q, ptr_q, sel16_q);
        else if (dp_idx_q == bscu_pkg::IDX_AUTO)
          hrdata_q[7:0] <= {auto_en_q, !busy, start_q};
        else if (dp_idx_q == bscu_pkg::IDX_CNT)
          hrdata_q[7:0] <= {2'b00, cnt_q};
      end
    end
  end

  // control fields; the init strobe is not stored
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sel16_q <= bscu_pkg::CTRL_RST[bscu_pkg::CTRL_SEL_BIT];
      seed_ones_q <= bscu_pkg::CTRL_RST[bscu_pkg::CTRL_VAL_BIT];
      ptr_q <= bscu_pkg::CTRL_RST[bscu_pkg::CTRL_PTR_LSB +: 2];
    end
    else if (ctrl_wr)
    begin
      sel16_q <= hwdata_i[bscu_pkg::CTRL_SEL_BIT];
      seed_ones_q <= hwdata_i[bscu_pkg::CTRL_VAL_BIT];
      ptr_q <= hwdata_i[bscu_pkg::CTRL_PTR_LSB +: 2];
    end
    else if (data_wr || data_rd)
      ptr_q <= ptr_q + 2'd1;
  end

  // input byte, auto control and sector count registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      in_q <= bscu_pkg::IN_RST;
      auto_en_q <= bscu_pkg::AUTO_RST[bscu_pkg::AUTO_EN_BIT];
      start_q <= bscu_pkg::AUTO_RST[bscu_pkg::AUTO_START_LSB +: 6];
      cnt_q <= bscu_pkg::CNT_RST[5:0];
    end
    else
    begin
      if (in_wr)
        in_q <= hwdata_i[7:0];
      if (auto_wr)
      begin
        auto_en_q <= hwdata_i[bscu_pkg::AUTO_EN_BIT];
        start_q <= hwdata_i[bscu_pkg::AUTO_START_LSB +: 6];
      end
      if (cnt_wr)
        cnt_q <= hwdata_i[5:0];
    end
  end

  // one engine serves register writes and the flash run alike
  assign eng_byte = (st_q == bscu_pkg::BSCU_FOLD) ? mem_rdata
                                                  : hwdata_i[7:0];

  bscu_crc_engine u_engine (
    .acc_i(acc_q),
    .byte_i(eng_byte),
    .sel16_i(sel16_q),
    .acc_o(eng_acc)
  );

  // accumulator; a reload in the same write as a start wins first,
  // the run then begins from the fresh seed one cycle later
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      acc_q <= bscu_pkg::ACC_RST;
    else if (ctrl_wr && hwdata_i[bscu_pkg::CTRL_INIT_BIT])
      acc_q <= hwdata_i[bscu_pkg::CTRL_VAL_BIT] ? bscu_pkg::SEED_ONES
                                                 : bscu_pkg::SEED_ZEROS;
    else if (data_wr)
      acc_q <= put_byte(acc_q, ptr_q, sel16_q, hwdata_i[7:0]);
    else if (in_wr)
      acc_q <= eng_acc;
    else if (st_q == bscu_pkg::BSCU_FOLD)
      acc_q <= eng_acc;
  end // otherwise it holds

  // automatic flash run: read a byte, fold it, step upward
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= bscu_pkg::BSCU_IDLE;
      faddr_q <= 16'h0000;
      left_q <= 16'h0000;
    end
    else
    begin
      case (st_q)
        bscu_pkg::BSCU_IDLE:
        begin
          if (auto_go)
          begin
            st_q <= bscu_pkg::BSCU_READ;
            faddr_q <= {start_q, 10'h000};
            left_q <= {cnt_q, 10'h000};
          end
        end
        bscu_pkg::BSCU_READ:
          st_q <= bscu_pkg::BSCU_FOLD;
        bscu_pkg::BSCU_FOLD:
        begin
          faddr_q <= faddr_q + 16'd1;
          left_q <= left_q - 16'd1;
          if (left_q == 16'd1)
            st_q <= bscu_pkg::BSCU_IDLE;
          else
            st_q <= bscu_pkg::BSCU_READ;
        end
        default:
          st_q <= bscu_pkg::BSCU_IDLE;
      endcase
    end
  end

  bscu_flash_mem #(
    .AW(bscu_pkg::FLASH_AW),
    .DW(8)
  ) u_flash (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(flash_wr_en_i),
    .wr_addr_i(flash_wr_addr_i),
    .wr_data_i(flash_wr_data_i),
    .rd_en_i(st_q == bscu_pkg::BSCU_READ),
    .rd_addr_i(faddr_q),
    .rd_data_o(mem_rdata)
  );

  // a control write with a set auto enable
  sequence s_auto_start;
    ctrl_wr && auto_en_q && (cnt_q != 6'h00);
  endsequence

  a_init_seed_load: assert property (
    ctrl_wr && hwdata_i[3] |=> acc_q == {32{$past(hwdata_i[2])}})
    else $error("init write did not load the chosen seed");

  a_zero_fold_zero: assert property (
    in_wr && !sel16_q && acc_q == 32'h0000_0000 && hwdata_i[7:0] == 8'h00
    |=> acc_q == 32'h0000_0000)
    else $error("zero byte on zero accumulator changed result");

  a_short_upper_kept: assert property (
    in_wr && sel16_q |=> acc_q[31:16] == $past(acc_q[31:16]))
    else $error("short mode disturbed upper half");

  a_ptr_advance: assert property (
    data_wr || data_rd |=> ptr_q == $past(ptr_q) + 2'd1)
    else $error("pointer did not advance after data access");

  a_ctrl_top_zero: assert property (
    rd_fire && dp_idx_q == 8'h92 |=> hrdata_q[7:5] == 3'b000)
    else $error("control unused bits not zero");

  a_auto_cpu_hold: assert property (
    s_auto_start |=> cpu_hold_o && faddr_q == {$past(start_q), 10'h000})
    else $error("auto run did not start at sector base");

  a_run_ascends: assert property (
    st_q == bscu_pkg::BSCU_FOLD && left_q != 16'd1
    |=> ##1 st_q == bscu_pkg::BSCU_FOLD
    && faddr_q == $past(faddr_q, 2) + 16'd1)
    else $error("flash fetch not ascending");

  a_acc_holds: assert property (
    !ctrl_wr && !data_wr && !in_wr && st_q != bscu_pkg::BSCU_FOLD
    |=> $stable(acc_q))
    else $error("accumulator changed without cause");

  a_short_read_map: assert property (
    data_rd && sel16_q && ptr_q[0] |=> hrdata_q[7:0] == $past(acc_q[15:8]))
    else $error("short mode pointer mapping wrong");

endmodule : bscu_top

// [tb/tb_byte_stream_crc_unit.sv]
// self-checking bench of the byte stream checksum unit
`timescale 1ns/1ps
module tb_byte_stream_crc_unit;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic fl_en = 1'b0;
  logic [15:0] fl_addr = 16'h0000;
  logic [7:0] fl_data = 8'h00;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic cpu_hold;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  bscu_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .flash_wr_en_i(fl_en), .flash_wr_addr_i(fl_addr),
    .flash_wr_data_i(fl_data), .cpu_hold_o(cpu_hold));

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // a hang counts as a mismatch
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_fail++;
      conclude();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // single ahb-lite word transfer; hready looked at just before each edge
  task ahb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
           output logic [7:0] rd);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(negedge clk_i);
    while (hready !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(negedge clk_i);
    while (hready !== 1'b1) @(negedge clk_i);
    rd = hrdata[7:0];
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    @(posedge clk_i);
  endtask : ahb

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    ahb(1'b1, idx, wd, d);
  endtask : wr

  task rd(input logic [7:0] idx, output logic [7:0] v);
    ahb(1'b0, idx, 8'h00, v);
  endtask : rd

  // four data port reads, least significant byte first
  task rd_res(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd(bscu_pkg::IDX_DATA, b);
      v[8*i +: 8] = b;
    end
  endtask : rd_res

  // independent reflected long-mode update
  function automatic logic [31:0] ref32(logic [31:0] a, logic [7:0] b);
    a = a ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      a = a[0] ? ((a >> 1) ^ 32'hEDB8_8320) : (a >> 1);
    return a;
  endfunction : ref32

  // flash pattern; sector 1 differs from sector 0
  function automatic logic [7:0] pat(logic [15:0] a);
    return a[7:0] ^ (a[10] ? 8'h5A : 8'h00) ^ {6'h0, a[9:8]};
  endfunction : pat

  task t_reset;
    logic [7:0] v;
    rd(bscu_pkg::IDX_CTRL, v);
    chk("ctrl reset", {24'h0, v}, 32'h0000_0000);
    rd(8'h90, v);
    chk("unmapped", {24'h0, v}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task t_long;
    logic [31:0] r;
    wr(bscu_pkg::IDX_CTRL, 8'h0C);
    wr(bscu_pkg::IDX_IN, 8'h63);
    rd_res(r);
    chk("long 63", r, 32'hF946_2090);
    wr(bscu_pkg::IDX_CTRL, 8'h0C);
    wr(bscu_pkg::IDX_IN, 8'hAA);
    wr(bscu_pkg::IDX_IN, 8'hBB);
    wr(bscu_pkg::IDX_IN, 8'hCC);
    rd_res(r);
    chk("long aabbcc", r, 32'h41B2_07B3);
    rd_res(r);
    chk("pointer wrap", r, 32'h41B2_07B3);
    wr(bscu_pkg::IDX_CTRL, 8'h08);
    rd_res(r);
    chk("init zeros", r, 32'h0000_0000);
    wr(bscu_pkg::IDX_IN, 8'h00);
    rd_res(r);
    chk("zero fold", r, 32'h0000_0000);
    $display("test long mode done");
  endtask : t_long

  task t_short;
    logic [7:0] lo;
    logic [7:0] hi;
    wr(bscu_pkg::IDX_CTRL, 8'h1C);
    wr(bscu_pkg::IDX_IN, 8'h63);
    rd(bscu_pkg::IDX_DATA, lo);
    rd(bscu_pkg::IDX_DATA, hi);
    chk("short 63", {16'h0, hi, lo}, 32'h0000_BD35);
    wr(bscu_pkg::IDX_CTRL, 8'h1C);
    wr(bscu_pkg::IDX_IN, 8'hAA);
    wr(bscu_pkg::IDX_IN, 8'hBB);
    wr(bscu_pkg::IDX_IN, 8'hCC);
    // pointer 10 must alias the low byte in short mode
    wr(bscu_pkg::IDX_CTRL, 8'h12);
    rd(bscu_pkg::IDX_DATA, lo);
    rd(bscu_pkg::IDX_DATA, hi);
    chk("short ptr2", {16'h0, hi, lo}, 32'h0000_6CF6);
    $display("test short mode done");
  endtask : t_short

  task t_ctrl_data;
    logic [7:0] v;
    logic [31:0] r;
    wr(bscu_pkg::IDX_CTRL, 8'hED);
    rd(bscu_pkg::IDX_CTRL, v);
    chk("ctrl readback", {24'h0, v}, 32'h0000_0005);
    wr(bscu_pkg::IDX_CTRL, 8'h00);
    wr(bscu_pkg::IDX_DATA, 8'h11);
    wr(bscu_pkg::IDX_DATA, 8'h22);
    rd(bscu_pkg::IDX_CTRL, v);
    chk("ptr after writes", {24'h0, v}, 32'h0000_0002);
    wr(bscu_pkg::IDX_DATA, 8'h33);
    wr(bscu_pkg::IDX_DATA, 8'h44);
    wr(bscu_pkg::IDX_IN, 8'h5E);
    rd(bscu_pkg::IDX_IN, v);
    chk("input readback", {24'h0, v}, 32'h0000_005E);
    rd_res(r);
    chk("overwrite fold", r, ref32(32'h4433_2211, 8'h5E));
    $display("test control and data port done");
  endtask : t_ctrl_data

  task t_auto;
    logic [7:0] v;
    logic [31:0] r;
    logic [31:0] e;
    int n;
    for (int a = 0; a < 2048; a++)
    begin
      @(posedge clk_i);
      fl_en <= 1'b1;
      fl_addr <= a[15:0];
      fl_data <= pat(a[15:0]);
    end
    @(posedge clk_i);
    fl_en <= 1'b0;
    // prepare, then start with a control write while enabled
    wr(bscu_pkg::IDX_CTRL, 8'h0C);
    wr(bscu_pkg::IDX_AUTO, 8'h01);
    wr(bscu_pkg::IDX_AUTO, 8'h81);
    wr(bscu_pkg::IDX_CNT, 8'h01);
    rd(bscu_pkg::IDX_CNT, v);
    chk("count readback", {24'h0, v}, 32'h0000_0001);
    wr(bscu_pkg::IDX_CTRL, 8'h04);
    repeat (2) @(negedge clk_i);
    chk("cpu hold", {31'h0, cpu_hold}, 32'h0000_0001);
    n = 0;
    while (cpu_hold !== 1'b0 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("run ended", {31'h0, cpu_hold}, 32'h0000_0000);
    // two cycles per byte; the first two held cycles passed before counting
    chk("run cycles", n, 2 * bscu_pkg::SECTOR_BYTES - 1);
    wr(bscu_pkg::IDX_AUTO, 8'h01);
    rd(bscu_pkg::IDX_AUTO, v);
    chk("done idle", {24'h0, v}, 32'h0000_0041);
    wr(bscu_pkg::IDX_CTRL, 8'h04);
    e = 32'hFFFF_FFFF;
    for (int a = 1024; a < 2048; a++)
      e = ref32(e, pat(a[15:0]));
    rd_res(r);
    chk("auto result", r, e);
    $display("test auto run done");
  endtask : t_auto

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_long();
    t_short();
    t_ctrl_data();
    t_auto();
    conclude();
  end
endmodule : tb_byte_stream_crc_unit
